/* cca_params.svh */
// Register offsets, field positions and reset values for the counter array modules
`ifndef CCA_PARAMS_SVH
`define CCA_PARAMS_SVH
`define CCA_MODE0_ADDR     8'hDA
`define CCA_MODE1_ADDR     8'hDB
`define CCA_MODE2_ADDR     8'hDC
`define CCA_MODE3_ADDR     8'hDD
`define CCA_MODE4_ADDR     8'hDE
`define CCA_MODE5_ADDR     8'hDF
`define CCA_LOW0_ADDR      8'hFB
`define CCA_LOW1_ADDR      8'hE9
`define CCA_LOW2_ADDR      8'hEB
`define CCA_LOW3_ADDR      8'hED
`define CCA_LOW4_ADDR      8'hFD
`define CCA_LOW5_ADDR      8'hD2
`define CCA_HIGH0_ADDR     8'hFC
`define CCA_HIGH1_ADDR     8'hEA
`define CCA_HIGH2_ADDR     8'hEC
`define CCA_HIGH3_ADDR     8'hEE
`define CCA_HIGH4_ADDR     8'hFE
`define CCA_HIGH5_ADDR     8'hD3
`define CCA_MODE_RESET     8'h00
`define CCA_CCR_RESET      16'h0000
`define CCA_BIT_WIDE       7
`define CCA_BIT_COMP       6
`define CCA_BIT_RISE       5
`define CCA_BIT_FALL       4
`define CCA_BIT_MATCH      3
`define CCA_BIT_TOGGLE     2
`define CCA_BIT_PWM        1
`define CCA_BIT_MASK       0
`endif

/* cca_pkg.sv */
// Types shared by the counter array capture/compare modules
package cca_pkg;
    // Mode control register, bit 7 first
    typedef struct packed {
        logic wide_pulse_select;
        logic comparator_enable;
        logic rising_capture_enable;
        logic falling_capture_enable;
        logic match_enable;
        logic toggle_enable;
        logic pulse_width_enable;
        logic module_flag_irq_mask;
    } cca_mode_s;

    // Byte write request toward one module's capture/compare register
    typedef struct packed {
        logic       wr_low;
        logic       wr_high;
        logic [7:0] data;
    } cca_ccr_wr_s;
endpackage : cca_pkg

/* cca_module.sv */
// One capture/compare module: capture, match, toggle and pulse-width output
`timescale 1ns/1ps
`include "cca_params.svh"
module cca_module (
    input  wire logic                 ref_clk_in,    // System clock
    input  wire logic                 reset_n_in,    // Synchronous reset, active low
    input  wire logic [15:0]          counter_in,    // Shared counter value
    input  cca_pkg::cca_mode_s        mode_in,       // Mode control bits
    input  cca_pkg::cca_ccr_wr_s      wr_in,         // Software byte writes
    input  wire logic                 rise_in,       // Filtered rising edge of pin
    input  wire logic                 fall_in,       // Filtered falling edge of pin
    output logic [15:0]               ccr_out,       // Capture/compare register
    output logic                      pin_out,       // Module external pin level
    output logic                      event_out      // Flag set request, one cycle
);
    logic        capture;
    logic        match_now;
    logic        match_q;
    logic        match_evt;
    logic        toggle_q;
    logic        pwm_q;
    logic        next_pwm;

    // Capture on enabled edges of the module pin
    assign capture   = (mode_in.rising_capture_enable & rise_in)
                     | (mode_in.falling_capture_enable & fall_in);

    // Match counts once per arrival, so toggling does not chatter while equal
    assign match_now = mode_in.comparator_enable & (counter_in == ccr_out);
    assign match_evt = match_now & ~match_q;
    assign event_out = capture | (match_evt & mode_in.match_enable);

    // Capture/compare register; a capture beats a software write in the same cycle
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ccr_out <= `CCA_CCR_RESET;
        end else if (capture) begin
            ccr_out <= counter_in;
        end else begin
            if (wr_in.wr_low) begin
                ccr_out[7:0] <= wr_in.data;
            end
            if (wr_in.wr_high) begin
                ccr_out[15:8] <= wr_in.data;
            end
        end
    end

    // Match history for edge detection
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_now;
        end
    end

    // Toggle output state
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            toggle_q <= 1'b0;
        end else if (match_evt & mode_in.toggle_enable) begin
            toggle_q <= ~toggle_q;
        end
    end

    // Pulse width: high once the counter reaches the compare value
    always_comb begin
        if (mode_in.wide_pulse_select) begin
            next_pwm = (counter_in >= ccr_out);
        end else begin
            next_pwm = (counter_in[7:0] >= ccr_out[7:0]);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pwm_q <= 1'b0;
        end else begin
            pwm_q <= next_pwm;
        end
    end

    // Width select only matters through the pulse-width path
    assign pin_out = mode_in.pulse_width_enable ? pwm_q : toggle_q;

    // Falling capture loads the counter on the next edge
    fall_capture_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (fall_in && mode_in.falling_capture_enable) |=> (ccr_out == $past(counter_in)))
        else $error("falling edge capture missed");

    // No edge enable, no capture change unless software wrote
    no_capture_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (!mode_in.rising_capture_enable && !mode_in.falling_capture_enable && !wr_in.wr_low && !wr_in.wr_high)
        |=> $stable(ccr_out))
        else $error("capture without enable");

    // Match with match enabled raises the event
    match_event_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (mode_in.comparator_enable && counter_in == ccr_out && !match_q) |->
        (event_out == (mode_in.match_enable || capture)))
        else $error("match event wrong");

    // Eight-bit pulse output follows the low byte compare
    pwm_narrow_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (mode_in.pulse_width_enable && !mode_in.wide_pulse_select) ##1
        ($stable(mode_in) && $stable(ccr_out))
        |-> pin_out == ($past(counter_in[7:0]) >= ccr_out[7:0]))
        else $error("8-bit pulse output wrong");

    // Sixteen-bit pulse output follows the full compare
    pwm_wide_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (mode_in.pulse_width_enable && mode_in.wide_pulse_select) ##1
        ($stable(mode_in) && $stable(ccr_out))
        |-> pin_out == ($past(counter_in) >= ccr_out))
        else $error("16-bit pulse output wrong");

    // Pulse mode off: pin shows toggle state whatever the width select
    width_ignored_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        !mode_in.pulse_width_enable |-> pin_out == toggle_q)
        else $error("width select leaked");

    // Toggle flips the pin once per match arrival
    toggle_pin_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (match_evt && mode_in.toggle_enable && !mode_in.pulse_width_enable ##1 !mode_in.pulse_width_enable)
        |-> pin_out != $past(pin_out))
        else $error("toggle missing");
endmodule : cca_module

/* cca_top.sv */
// Six capture/compare modules of the counter array with their register access
// Notes on behaviour
// - Width select acts only while pulse-width output is enabled.
// - Width select 0 gives 8-bit pulse width; 1 gives 16-bit.
// - Falling capture enable loads shared counter on each falling pin edge.
// - Match enable, with comparator enable set, sets module flag when counter arrives at compare register.
// - High byte of compare value sits in its own register beside low byte.
`timescale 1ns/1ps
`include "cca_params.svh"
module cca_top #(
    parameter int NUM_MODULES = 6                        // Capture/compare modules
) (
    input  wire logic                   ref_clk_in,        // System clock, 100 MHz
    input  wire logic                   reset_n_in,        // Synchronous reset, active low
    input  wire logic [7:0]             sfr_addr_in,       // Register address
    input  wire logic                   sfr_wr_in,         // Register write strobe
    input  wire logic                   sfr_rd_in,         // Register read strobe
    input  wire logic [7:0]             sfr_wdata_in,      // Write data
    output logic [7:0]                  sfr_rdata_out,     // Read data, one cycle later
    input  wire logic [15:0]            counter_value_in,  // Shared counter
    input  wire logic [NUM_MODULES-1:0] pin_in,            // Module external pins, async
    output logic [NUM_MODULES-1:0]      pin_out,           // Module external pin drive
    input  wire logic [NUM_MODULES-1:0] flag_clear_in,     // Flag clear from core
    output logic [NUM_MODULES-1:0]      event_flag_out,    // Sticky module event flags
    output logic                        irq_out            // Masked flag request
);
    localparam logic [7:0] MODE_ADDR [6] = '{`CCA_MODE0_ADDR, `CCA_MODE1_ADDR, `CCA_MODE2_ADDR,
                                             `CCA_MODE3_ADDR, `CCA_MODE4_ADDR, `CCA_MODE5_ADDR};
    localparam logic [7:0] LOW_ADDR [6]  = '{`CCA_LOW0_ADDR, `CCA_LOW1_ADDR, `CCA_LOW2_ADDR,
                                             `CCA_LOW3_ADDR, `CCA_LOW4_ADDR, `CCA_LOW5_ADDR};
    localparam logic [7:0] HIGH_ADDR [6] = '{`CCA_HIGH0_ADDR, `CCA_HIGH1_ADDR, `CCA_HIGH2_ADDR,
                                             `CCA_HIGH3_ADDR, `CCA_HIGH4_ADDR, `CCA_HIGH5_ADDR};

    cca_pkg::cca_mode_s          mode [NUM_MODULES];
    logic [15:0]                 ccr [NUM_MODULES];
    logic [NUM_MODULES-1:0]      sync1;
    logic [NUM_MODULES-1:0]      sync2;
    logic [NUM_MODULES-1:0]      sync3;
    logic [NUM_MODULES-1:0]      pin_level;
    logic [NUM_MODULES-1:0]      rise;
    logic [NUM_MODULES-1:0]      fall;
    logic [NUM_MODULES-1:0]      evt;
    logic [NUM_MODULES-1:0]      mask_vec;
    logic [7:0]                  next_rdata;

    // Three-stage pin synchroniser; a level counts once stages two and three agree
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            sync1     <= '0;
            sync2     <= '0;
            sync3     <= '0;
            pin_level <= '0;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < NUM_MODULES; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_level[i] <= sync3[i];
                end
            end
        end
    end

    // Edges taken from the filtered level, not the raw stages
    always_comb begin
        for (int i = 0; i < NUM_MODULES; i++) begin
            rise[i] = (sync2[i] == sync3[i]) & sync3[i] & ~pin_level[i];
            fall[i] = (sync2[i] == sync3[i]) & ~sync3[i] & pin_level[i];
        end
    end

    // Mode registers written by software
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_MODULES; i++) begin
                mode[i] <= `CCA_MODE_RESET;
            end
        end else if (sfr_wr_in) begin
            for (int i = 0; i < NUM_MODULES; i++) begin
                if (sfr_addr_in == MODE_ADDR[i]) begin
                    mode[i] <= sfr_wdata_in;
                end
            end
        end
    end

    // Per-module logic
    for (genvar g = 0; g < NUM_MODULES; g++) begin : g_mod
        cca_pkg::cca_ccr_wr_s wr;
        assign wr.wr_low  = sfr_wr_in & (sfr_addr_in == LOW_ADDR[g]);
        assign wr.wr_high = sfr_wr_in & (sfr_addr_in == HIGH_ADDR[g]);
        assign wr.data    = sfr_wdata_in;
        assign mask_vec[g] = mode[g].module_flag_irq_mask;

        cca_module u_mod (
            .ref_clk_in (ref_clk_in),
            .reset_n_in (reset_n_in),
            .counter_in (counter_value_in),
            .mode_in    (mode[g]),
            .wr_in      (wr),
            .rise_in    (rise[g]),
            .fall_in    (fall[g]),
            .ccr_out    (ccr[g]),
            .pin_out    (pin_out[g]),
            .event_out  (evt[g])
        );
    end

    // Sticky flags; an event in the clearing cycle wins
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            event_flag_out <= '0;
        end else begin
            event_flag_out <= (event_flag_out & ~flag_clear_in) | evt;
        end
    end

    // Mask gates each flag onto the request line
    assign irq_out = |(event_flag_out & mask_vec);

    // Read decode; unmapped addresses return zero
    always_comb begin
        next_rdata = 8'h00;
        for (int i = 0; i < NUM_MODULES; i++) begin
            if (sfr_addr_in == MODE_ADDR[i]) begin
                next_rdata = mode[i];
            end
            if (sfr_addr_in == LOW_ADDR[i]) begin
                next_rdata = ccr[i][7:0];
            end
            if (sfr_addr_in == HIGH_ADDR[i]) begin
                next_rdata = ccr[i][15:8];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_rd_in) begin
            sfr_rdata_out <= next_rdata;
        end
    end

    // Event with clear in the same cycle still leaves the flag set
    flag_set_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        evt[0] |=> event_flag_out[0])
        else $error("event flag not set");

    // A clear drops every flag whose clear bit is set and whose module had no event that cycle
    flag_clear_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (flag_clear_in != '0) |=> (event_flag_out & $past(flag_clear_in) & ~$past(evt)) == '0)
        else $error("flag clear ignored");

    // Without a clear a raised flag stays raised, so software never misses it
    flag_sticky_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (event_flag_out != '0) |=> ($past(event_flag_out) & ~$past(flag_clear_in) & ~event_flag_out) == '0)
        else $error("flag dropped without clear");

    // Request follows masked flags
    irq_mask_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (event_flag_out[0] && !mode[0].module_flag_irq_mask && event_flag_out[NUM_MODULES-1:1] == '0)
        |-> !irq_out)
        else $error("masked flag raised request");

    // An unmasked flag always reaches the request line
    irq_raise_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (event_flag_out[0] && mode[0].module_flag_irq_mask) |-> irq_out)
        else $error("unmasked flag gave no request");

    // No flag, no request, whatever the masks say
    irq_idle_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (event_flag_out == '0) |-> !irq_out)
        else $error("request without flag");

    // Mode write lands at the taking edge
    mode_write_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (sfr_wr_in && sfr_addr_in == MODE_ADDR[0]) |=> mode[0] == $past(sfr_wdata_in))
        else $error("mode write lost");

    // Mode read returns the stored enables
    mode_read_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (sfr_rd_in && sfr_addr_in == MODE_ADDR[0]) |=> sfr_rdata_out == $past(mode[0]))
        else $error("mode read wrong");

    // Low byte read returns the lower compare byte
    low_read_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (sfr_rd_in && sfr_addr_in == LOW_ADDR[0]) |=> sfr_rdata_out == $past(ccr[0][7:0]))
        else $error("low byte read wrong");

    // High byte read returns the upper compare byte
    high_read_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (sfr_rd_in && sfr_addr_in == HIGH_ADDR[0]) |=> sfr_rdata_out == $past(ccr[0][15:8]))
        else $error("high byte read wrong");

    // Read data holds between strobes, so a slow core may fetch it late
    read_hold_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        !sfr_rd_in |=> $stable(sfr_rdata_out))
        else $error("read data moved without strobe");

    // Low byte write lands when no capture competes
    low_write_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (sfr_wr_in && sfr_addr_in == LOW_ADDR[0] && !rise[0] && !fall[0]) |=> ccr[0][7:0] == $past(sfr_wdata_in))
        else $error("low byte write lost");

    // High byte write lands in its own register
    high_write_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (sfr_wr_in && sfr_addr_in == HIGH_ADDR[0] && !rise[0] && !fall[0]) |=> ccr[0][15:8] == $past(sfr_wdata_in))
        else $error("high byte write lost");

    // Filtered level follows once stages two and three agree
    level_follow_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (sync2[0] == sync3[0]) |=> pin_level[0] == $past(sync3[0]))
        else $error("pin level did not follow");

    // A falling edge pulse lasts one cycle, so one edge captures once
    fall_single_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        fall[0] |=> !fall[0])
        else $error("falling edge pulse repeated");
endmodule : cca_top

/* cca_top_tb_top.sv */
// Self-checking bench for the six capture/compare modules and their registers
`timescale 1ns/1ps
`include "cca_params.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("FAIL %0t got %h expected %h", $time, got, exp); end end
module cca_top_tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_pend = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [15:0] cnt = 16'h0000, v;
    logic [5:0]  pin = 6'h00, fclr = 6'h00, pin_o, flag;
    logic        irq, p0, wide;
    logic [31:0] seed = 32'h1a5f_7756;
    logic [7:0]  exp_q[$];
    logic [7:0]  exp_rd;
    int          n_errors = 0, tests_run = 0;
    logic [7:0]  md[6] = '{`CCA_MODE0_ADDR, `CCA_MODE1_ADDR, `CCA_MODE2_ADDR,
                           `CCA_MODE3_ADDR, `CCA_MODE4_ADDR, `CCA_MODE5_ADDR};
    logic [7:0]  lo[6] = '{`CCA_LOW0_ADDR, `CCA_LOW1_ADDR, `CCA_LOW2_ADDR,
                           `CCA_LOW3_ADDR, `CCA_LOW4_ADDR, `CCA_LOW5_ADDR};
    logic [7:0]  hi[6] = '{`CCA_HIGH0_ADDR, `CCA_HIGH1_ADDR, `CCA_HIGH2_ADDR,
                           `CCA_HIGH3_ADDR, `CCA_HIGH4_ADDR, `CCA_HIGH5_ADDR};

    cca_top cca_top_i (.ref_clk_in(clk), .reset_n_in(rst_n), .sfr_addr_in(addr), .sfr_wr_in(wr),
        .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .counter_value_in(cnt),
        .pin_in(pin), .pin_out(pin_o), .flag_clear_in(fclr), .event_flag_out(flag), .irq_out(irq));

    // Free-running 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // Read data lands at the taking edge; checked mid-cycle to stay off the edge
    always @(posedge clk) rd_pend <= rd;
    always @(negedge clk) begin
        if (rd_pend) begin
            exp_rd = exp_q.pop_front(); // Taken once, so a mismatch print cannot pop again
            `CHK(rdata, exp_rd)
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : w
    task automatic r(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask : r
    task automatic wcc(input int m, input logic [15:0] d);
        w(lo[m], d[7:0]);
        w(hi[m], d[15:8]);
    endtask : wcc
    task automatic rcc(input int m, input logic [15:0] e);
        r(lo[m], e[7:0]);
        r(hi[m], e[15:8]);
    endtask : rcc
    task automatic drv(input logic [15:0] c, input logic [5:0] p);
        @(posedge clk);
        cnt <= c; pin <= p;
    endtask : drv
    task automatic clr_flags();
        @(posedge clk);
        fclr <= 6'h3f;
        @(posedge clk);
        fclr <= 6'h00;
    endtask : clr_flags
    // Counter walks across the compare value so equality arrives once
    task automatic sweep(input logic [15:0] c);
        drv(c - 16'h0001, pin);
        drv(c, pin);
        drv(c + 16'h0001, pin);
        cyc(3);
    endtask : sweep

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // Hang guard, well past the expected few hundred cycles
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        cyc(10);
        @(posedge clk) rst_n <= 1'b1;
        // Reset values, random write and read-back, unmapped address
        for (int m = 0; m < 6; m++) begin
            r(md[m], `CCA_MODE_RESET);
            rcc(m, `CCA_CCR_RESET);
        end
        for (int m = 0; m < 6; m++) begin
            seed = xs(seed);
            w(md[m], seed[7:0]);
            wcc(m, seed[31:16]);
            r(md[m], seed[7:0]);
            rcc(m, seed[31:16]);
            w(md[m], 8'h00);
        end
        w(8'h80, 8'h5a);
        r(8'h80, 8'h00);
        clr_flags();
        $display("register test done");
        // Falling capture on module 2, rising ignored while its enable is clear
        seed = xs(seed);
        wcc(2, 16'h0000);
        w(md[2], 8'h10);
        drv(seed[15:0], 6'h04);
        cyc(8);
        rcc(2, 16'h0000);
        `CHK(flag[2], 1'b0)
        drv(seed[15:0], 6'h00);
        cyc(8);
        rcc(2, seed[15:0]);
        `CHK(flag[2], 1'b1)
        w(md[2], 8'h20);
        drv(seed[31:16], 6'h04);
        cyc(8);
        rcc(2, seed[31:16]);
        drv(16'h0000, 6'h00);
        cyc(8);
        rcc(2, seed[31:16]);
        w(md[2], 8'h00);
        clr_flags();
        $display("capture test done");
        // Match flag, interrupt mask, toggle on module 4
        wcc(4, 16'h1234);
        w(md[4], 8'h48);
        sweep(16'h1234);
        `CHK(flag[4], 1'b1)
        `CHK(irq, 1'b0)
        w(md[4], 8'h49);
        cyc(2);
        `CHK(irq, 1'b1)
        clr_flags();
        w(md[4], 8'h40);
        sweep(16'h1234);
        `CHK(flag[4], 1'b0)
        p0 = pin_o[4];
        w(md[4], 8'h44);
        sweep(16'h1234);
        `CHK(pin_o[4], ~p0)
        w(md[4], 8'h00);
        $display("match test done");
        // Pulse width on module 1 with random counter and width select
        wcc(1, 16'h0180);
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            wide = seed[20];
            v = {6'h00, seed[9:0]};
            w(md[1], {wide, 7'h42});
            drv(v, 6'h00);
            cyc(3);
            `CHK(pin_o[1], wide ? (v >= 16'h0180) : (v[7:0] >= 8'h80))
        end
        // Width select alone leaves the pin alone
        w(md[1], 8'h40);
        cyc(3);
        p0 = pin_o[1];
        w(md[1], 8'hc0);
        for (int i = 0; i < 4; i++) begin
            drv(16'h0100 << i, 6'h00);
            cyc(3);
            `CHK(pin_o[1], p0)
        end
        $display("pulse width test done");
        cyc(4);
        tally_and_finish();
    end
endmodule : cca_top_tb_top
